// *** dtf_map.svh ***
// Constants of the debug trace FIFO: offsets, fields, resets, counts.
// Assumes a byte-wide register port with a 4-bit word address.
//
// Summary of operation
// - Address modes store 16-bit change-of-flow words, read high then low.
// - Every read of the low port byte shifts the FIFO so the next entry shows.
// - Event-only mode stores bytes, high byte unused, each low read shifts.
// - A change-of-flow at the start trigger or two cycles after is not stored.
// - In end-trace, a change-of-flow trigger is stored as the last entry if the FIFO has room for it.
// - While disarmed, each low read pushes the last fetched opcode address.
// - Only instructions that break sequential flow are recorded.
// - A taken conditional branch stores the address of the branch opcode.
// - Branch-always and branch-never store nothing.
// - Indirect jump and call store the run-time destination address.
// - Interrupt entry and both returns store the destination address.
// - A tag marks an opcode at fetch and fires only if that opcode executes.
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH
`define DTF_ADDR_HIGH 4'h0
`define DTF_ADDR_LOW 4'h1
`define DTF_ADDR_CTRL 4'h2
`define DTF_ADDR_STATUS 4'h3
`define DTF_CTRL_ARM 0
`define DTF_CTRL_EVENT 1
`define DTF_CTRL_END 2
`define DTF_CTRL_RESET 3'h0
`define DTF_STAT_RUN 4
`define DTF_STAT_DONE 5
`define DTF_STAT_FULL 6
`define DTF_DEPTH 8
`define DTF_SKIP_CYCLES 2'h2
`endif

// *** dtf_pkg.sv ***
// Types of the debug trace FIFO.
// Assumes the CPU reports each executed opcode with a class code.
package dtf_pkg;
   typedef enum {
      DTF_IDLE, DTF_WAIT, DTF_SKIP, DTF_RUN, DTF_DONE
   } dtf_state_t;
   typedef enum logic [3:0] {
      DTF_OP_SEQ = 4'h0,
      DTF_OP_COND = 4'h1,
      DTF_OP_BRANCH_ALWAYS = 4'h2,
      DTF_OP_BRANCH_NEVER = 4'h3,
      DTF_OP_JUMP_IND = 4'h4,
      DTF_OP_CALL_IND = 4'h5,
      DTF_OP_INTERRUPT = 4'h6,
      DTF_OP_INT_RETURN = 4'h7,
      DTF_OP_SUB_RETURN = 4'h8
   } dtf_op_t;
endpackage

// *** dtf_fifo_if.sv ***
// Link between the trace control logic and its entry store.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface dtf_fifo_if;
   logic push;
   logic [15:0] push_data;
   logic pop;
   logic [15:0] head;
   logic [3:0] count;
   logic full;
   modport ctl (output push, output push_data, output pop,
      input head, input count, input full);
   modport mem (input push, input push_data, input pop,
      output head, output count, output full);
endinterface

// *** dtf_fifo.sv ***
// Shift-style trace entry store; entry 0 is the port head.
// Assumes push is ignored when full unless a pop comes with it.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_fifo #(
   parameter int DEPTH = `DTF_DEPTH
) (
   input wire logic clock, // Bus clock
   input wire logic reset, // Asynchronous reset, high
   dtf_fifo_if.mem port // Control side
);
   if (DEPTH < 2 || DEPTH > 15) begin : g_depth_check
      $error("dtf_fifo: DEPTH must be 2 to 15");
   end

   logic [15:0] entry_reg [DEPTH];
   logic [3:0] count_reg;
   logic do_pop;
   logic do_push;
   logic [3:0] wr_slot;

   assign do_pop = port.pop && (count_reg != 4'h0);
   assign do_push = port.push && (count_reg != 4'(DEPTH) || do_pop);
   assign wr_slot = do_pop ? count_reg - 4'h1 : count_reg;

   ////////////////////////////////////////////////////////////////////
   // Entries shift toward the head on a pop
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            entry_reg[i] <= 16'h0000;
         end else if (do_push && wr_slot == 4'(i)) begin
            entry_reg[i] <= port.push_data;
         end else if (do_pop) begin
            entry_reg[i] <= (i == DEPTH - 1) ? 16'h0000
               : entry_reg[(i + 1) % DEPTH];
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_reg <= 4'h0;
      end else if (do_push && !do_pop) begin
         count_reg <= count_reg + 4'h1;
      end else if (do_pop && !do_push) begin
         count_reg <= count_reg - 4'h1;
      end
   end

   assign port.head = entry_reg[0];
   assign port.count = count_reg;
   assign port.full = (count_reg == 4'(DEPTH));
endmodule

// *** dtf_trace.sv ***
// Debug trace capture: change-of-flow or event data into a FIFO.
// Assumes CPU execute/fetch reports and trigger hits on the bus clock.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_trace #(
   parameter int DEPTH = `DTF_DEPTH
) (
   input wire logic clock, // Bus clock, 40 MHz
   input wire logic reset, // Asynchronous reset, high
   input wire logic [3:0] reg_addr, // Register word address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_write, // Write strobe
   input wire logic reg_read, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after read
   input wire logic fetch_valid, // Opcode fetched into queue
   input wire logic [15:0] fetch_addr, // Address of fetched opcode
   input wire logic fetch_tag, // Comparator match at fetch
   input wire logic queue_flush, // Queue thrown away
   input wire logic exec_valid, // Opcode executed this cycle
   input wire logic [15:0] exec_addr, // Address of executed opcode
   input wire dtf_pkg::dtf_op_t exec_class, // Kind of executed opcode
   input wire logic exec_taken, // Conditional branch taken
   input wire logic [15:0] exec_dest, // Run-time destination
   input wire logic event_valid, // Event-only data strobe
   input wire logic [7:0] event_data, // Event data byte
   input wire logic trigger_hit, // Trigger event pulse
   output logic tag_fire, // Tagged opcode executed
   output logic [3:0] fifo_valid_count // Valid entries
);
   if (DEPTH != `DTF_DEPTH) begin : g_depth_check
      $error("dtf_trace: FIFO must be eight deep");
   end

   dtf_fifo_if fifo ();

   dtf_fifo #(
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .port(fifo.mem)
   );

   dtf_pkg::dtf_state_t state_reg;
   dtf_pkg::dtf_state_t state_next;
   logic [2:0] ctrl_reg;
   logic [1:0] skip_reg;
   logic [15:0] last_fetch_reg;
   logic [7:0] rdata_reg;
   logic push_reg;
   logic [15:0] push_data_reg;
   logic tag_pending_reg;
   logic [15:0] tag_addr_reg;
   logic tag_fire_reg;
   logic armed;
   logic event_mode;
   logic end_mode;
   logic read_low;
   logic read_high;
   logic cof_hit;
   logic [15:0] cof_addr;
   logic capture;

   assign armed = ctrl_reg[`DTF_CTRL_ARM];
   assign event_mode = ctrl_reg[`DTF_CTRL_EVENT];
   assign end_mode = ctrl_reg[`DTF_CTRL_END];
   assign read_low = reg_read && reg_addr == `DTF_ADDR_LOW;
   assign read_high = reg_read && reg_addr == `DTF_ADDR_HIGH;

   ////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_reg <= `DTF_CTRL_RESET;
      end else if (reg_write && reg_addr == `DTF_ADDR_CTRL) begin
         ctrl_reg <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_reg <= 8'h00;
      end else if (read_high) begin
         rdata_reg <= event_mode ? 8'h00 : fifo.head[15:8];
      end else if (read_low) begin
         rdata_reg <= fifo.head[7:0];
      end else if (reg_read && reg_addr == `DTF_ADDR_CTRL) begin
         rdata_reg <= {5'h00, ctrl_reg};
      end else if (reg_read && reg_addr == `DTF_ADDR_STATUS) begin
         rdata_reg <= {1'b0, fifo.full, state_reg == dtf_pkg::DTF_DONE,
            state_reg == dtf_pkg::DTF_RUN, fifo.count};
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;
   assign fifo_valid_count = fifo.count;
   assign fifo.pop = read_low;

   ////////////////////////////////////////////////////////////////////
   // Change-of-flow selection
   always_comb begin
      cof_hit = 1'b0;
      cof_addr = exec_dest;
      if (exec_valid) begin
         case (exec_class)
            dtf_pkg::DTF_OP_COND: begin
               cof_hit = exec_taken;
               cof_addr = exec_addr;
            end
            dtf_pkg::DTF_OP_JUMP_IND,
            dtf_pkg::DTF_OP_CALL_IND: begin
               cof_hit = 1'b1;
            end
            dtf_pkg::DTF_OP_INTERRUPT,
            dtf_pkg::DTF_OP_INT_RETURN,
            dtf_pkg::DTF_OP_SUB_RETURN: begin
               cof_hit = 1'b1;
            end
            default: begin
               cof_hit = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capture sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dtf_pkg::DTF_IDLE: begin
            if (armed) begin
               state_next = end_mode ? dtf_pkg::DTF_RUN : dtf_pkg::DTF_WAIT;
            end
         end
         dtf_pkg::DTF_WAIT: begin
            if (trigger_hit) begin
               state_next = dtf_pkg::DTF_SKIP;
            end
         end
         dtf_pkg::DTF_SKIP: begin
            if (skip_reg == 2'h1) begin
               state_next = dtf_pkg::DTF_RUN;
            end
         end
         dtf_pkg::DTF_RUN: begin
            if (end_mode && trigger_hit) begin
               state_next = dtf_pkg::DTF_DONE;
            end else if (!end_mode && fifo.full) begin
               state_next = dtf_pkg::DTF_DONE;
            end
         end
         dtf_pkg::DTF_DONE: begin
            state_next = dtf_pkg::DTF_DONE;
         end
         default: begin
            state_next = dtf_pkg::DTF_IDLE;
         end
      endcase
      if (!armed) begin
         state_next = dtf_pkg::DTF_IDLE;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= dtf_pkg::DTF_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Pipeline delay: trigger cycle plus two more go unrecorded
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         skip_reg <= 2'h0;
      end else if (state_reg == dtf_pkg::DTF_WAIT && trigger_hit) begin
         skip_reg <= `DTF_SKIP_CYCLES;
      end else if (skip_reg != 2'h0) begin
         skip_reg <= skip_reg - 2'h1;
      end
   end

   assign capture = armed && state_reg == dtf_pkg::DTF_RUN;

   ////////////////////////////////////////////////////////////////////
   // FIFO input stage
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         last_fetch_reg <= 16'h0000;
      end else if (fetch_valid) begin
         last_fetch_reg <= fetch_addr;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         push_reg <= 1'b0;
         push_data_reg <= 16'h0000;
      end else if (!armed) begin
         push_reg <= read_low;
         push_data_reg <= last_fetch_reg;
      end else if (capture && event_mode) begin
         push_reg <= event_valid;
         push_data_reg <= {8'h00, event_data};
      end else if (capture) begin
         push_reg <= cof_hit;
         push_data_reg <= cof_addr;
      end else begin
         push_reg <= 1'b0;
         push_data_reg <= push_data_reg;
      end
   end

   assign fifo.push = push_reg;
   assign fifo.push_data = push_data_reg;

   ////////////////////////////////////////////////////////////////////
   // Tagging: mark at fetch, act only on execution
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tag_pending_reg <= 1'b0;
         tag_addr_reg <= 16'h0000;
      end else if (queue_flush) begin
         tag_pending_reg <= 1'b0;
      end else if (fetch_valid && fetch_tag) begin
         tag_pending_reg <= 1'b1;
         tag_addr_reg <= fetch_addr;
      end else if (tag_fire_reg) begin
         tag_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tag_fire_reg <= 1'b0;
      end else begin
         tag_fire_reg <= tag_pending_reg && !queue_flush && exec_valid
            && exec_addr == tag_addr_reg && !tag_fire_reg;
      end
   end

   assign tag_fire = tag_fire_reg;

   ////////////////////////////////////////////////////////////////////
   // Checks
   low_read_pop_a: assert property (
      @(posedge clock) disable iff (reset)
      read_low && armed && fifo.count != 4'h0 && !fifo.push
      |=> fifo.count == $past(fifo.count) - 4'h1)
      else $error("low read did not shift");

   high_byte_a: assert property (
      @(posedge clock) disable iff (reset)
      read_high && !event_mode |=> reg_rdata == $past(fifo.head[15:8]))
      else $error("high byte wrong");

   event_high_zero_a: assert property (
      @(posedge clock) disable iff (reset)
      read_high && event_mode |=> reg_rdata == 8'h00)
      else $error("event mode high byte not zero");

   skip_window_a: assert property (
      @(posedge clock) disable iff (reset)
      state_reg == dtf_pkg::DTF_WAIT && trigger_hit && armed
      |=> !fifo.push [*3])
      else $error("push inside skip window");

   uncond_branch_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && !event_mode && exec_valid
      && (exec_class == dtf_pkg::DTF_OP_BRANCH_ALWAYS
      || exec_class == dtf_pkg::DTF_OP_BRANCH_NEVER) |=> !fifo.push)
      else $error("unconditional branch stored");

   sequential_none_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && !event_mode && (!exec_valid
      || exec_class == dtf_pkg::DTF_OP_SEQ) |=> !fifo.push)
      else $error("sequential address stored");

   cond_source_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && !event_mode && exec_valid && exec_taken
      && exec_class == dtf_pkg::DTF_OP_COND
      |=> fifo.push && fifo.push_data == $past(exec_addr))
      else $error("branch source not stored");

   indirect_dest_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && !event_mode && exec_valid
      && (exec_class == dtf_pkg::DTF_OP_JUMP_IND
      || exec_class == dtf_pkg::DTF_OP_CALL_IND)
      |=> fifo.push && fifo.push_data == $past(exec_dest))
      else $error("indirect destination not stored");

   return_dest_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && !event_mode && exec_valid
      && (exec_class == dtf_pkg::DTF_OP_INTERRUPT
      || exec_class == dtf_pkg::DTF_OP_INT_RETURN
      || exec_class == dtf_pkg::DTF_OP_SUB_RETURN)
      |=> fifo.push && fifo.push_data == $past(exec_dest))
      else $error("return destination not stored");

   end_trace_last_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && end_mode && !event_mode && trigger_hit && cof_hit
      |=> fifo.push && state_reg == dtf_pkg::DTF_DONE ##1 !fifo.push)
      else $error("end trigger entry wrong");

   done_no_push_a: assert property (
      @(posedge clock) disable iff (reset)
      armed && state_reg == dtf_pkg::DTF_DONE |=> !fifo.push)
      else $error("entry stored after the run ended");

   profile_push_a: assert property (
      @(posedge clock) disable iff (reset)
      !armed && read_low ##1 !armed
      |-> fifo.push && fifo.push_data == $past(last_fetch_reg))
      else $error("profile push missing");

   event_byte_a: assert property (
      @(posedge clock) disable iff (reset)
      capture && event_mode && event_valid
      |=> fifo.push && fifo.push_data == {8'h00, $past(event_data)})
      else $error("event byte wrong");

   tag_flush_a: assert property (
      @(posedge clock) disable iff (reset)
      queue_flush |=> !tag_pending_reg ##1 !tag_fire)
      else $error("flushed tag fired");

   tag_exec_a: assert property (
      @(posedge clock) disable iff (reset)
      fetch_valid && fetch_tag && !queue_flush
      ##1 exec_valid && !queue_flush && !tag_fire
      && exec_addr == $past(fetch_addr) |=> tag_fire)
      else $error("executed tag did not fire");

   full_drop_a: assert property (
      @(posedge clock) disable iff (reset)
      fifo.full && fifo.push && !fifo.pop
      |=> fifo.count == 4'(DEPTH) && $stable(fifo.head))
      else $error("push into full store not dropped");

   fifo_depth_a: assert property (
      @(posedge clock) disable iff (reset)
      fifo_valid_count <= 4'(DEPTH))
      else $error("count above depth");
endmodule

// *** dtf_cpu_model.sv ***
// Behavioural CPU core: fetch, execute, flush, event and trigger reports.
// Assumes one caller process, one task call per bus cycle.
`timescale 1ns/1ps
module dtf_cpu_model (
   input wire logic clock, // Bus clock
   output logic fetch_valid, // Fetch strobe
   output logic [15:0] fetch_addr, // Fetched opcode address
   output logic fetch_tag, // Tag match at fetch
   output logic queue_flush, // Queue discard
   output logic exec_valid, // Execute strobe
   output logic [15:0] exec_addr, // Executed opcode address
   output dtf_pkg::dtf_op_t exec_class, // Opcode kind
   output logic exec_taken, // Branch taken
   output logic [15:0] exec_dest, // Run-time destination
   output logic event_valid, // Event strobe
   output logic [7:0] event_data, // Event byte
   output logic trigger_hit // Trigger pulse
);
   initial begin
      {fetch_valid, fetch_tag, queue_flush, exec_valid} = 4'h0;
      {exec_taken, event_valid, trigger_hit} = 3'h0;
      {fetch_addr, exec_addr, exec_dest} = 48'h0;
      event_data = 8'h00;
      exec_class = dtf_pkg::DTF_OP_SEQ;
   end
   ////////////////////////////////////////////////////////////////////////
   // Strobes; released data lines flip so stale values never match
   task automatic strobes(input logic fv, fl, xv, ev, tr);
      fetch_valid <= fv;
      queue_flush <= fl;
      exec_valid <= xv;
      event_valid <= ev;
      trigger_hit <= tr;
      if (!fv) begin
         fetch_addr <= ~fetch_addr;
         fetch_tag <= 1'b0;
      end
      if (!xv) begin
         exec_addr <= ~exec_addr;
         exec_dest <= ~exec_dest;
         exec_taken <= ~exec_taken;
      end
      if (!ev) begin
         event_data <= ~event_data;
      end
   endtask
   task automatic idle();
      @(posedge clock);
      strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic op(input dtf_pkg::dtf_op_t c, input logic [15:0] a,
         input logic tk, input logic [15:0] d, input logic tr);
      @(posedge clock);
      strobes(1'b0, 1'b0, 1'b1, 1'b0, tr);
      exec_class <= c;
      exec_addr <= a;
      exec_taken <= tk;
      exec_dest <= d;
   endtask
   task automatic fetch(input logic [15:0] a, input logic tg);
      @(posedge clock);
      strobes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      fetch_addr <= a;
      fetch_tag <= tg;
   endtask
   task automatic flush();
      @(posedge clock);
      strobes(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
   endtask
   task automatic send_event(input logic [7:0] d);
      @(posedge clock);
      strobes(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      event_data <= d;
   endtask
   task automatic trig();
      @(posedge clock);
      strobes(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
   endtask
endmodule

// *** dtf_trace_test.sv ***
// Self-checking bench of the trace FIFO block.
// Assumes the CPU model and the register map header.
`timescale 1ns/1ps
`include "dtf_map.svh"
module dtf_trace_test;
   logic clock, reset, reg_write, reg_read, tag_fire;
   logic [3:0] reg_addr, fifo_valid_count;
   logic [7:0] reg_wdata, reg_rdata, b;
   logic [15:0] w;
   logic fetch_valid, fetch_tag, queue_flush, exec_valid, exec_taken;
   logic event_valid, trigger_hit;
   logic [15:0] fetch_addr, exec_addr, exec_dest;
   logic [7:0] event_data;
   dtf_pkg::dtf_op_t exec_class;
   int err_count = 0;
   int n_checks = 0;
   dtf_trace #(.DEPTH(8)) dut (.clock(clock), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .fetch_tag(fetch_tag), .queue_flush(queue_flush),
      .exec_valid(exec_valid), .exec_addr(exec_addr),
      .exec_class(exec_class), .exec_taken(exec_taken),
      .exec_dest(exec_dest), .event_valid(event_valid),
      .event_data(event_data), .trigger_hit(trigger_hit),
      .tag_fire(tag_fire), .fifo_valid_count(fifo_valid_count));
   dtf_cpu_model cpu (.clock(clock), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .fetch_tag(fetch_tag),
      .queue_flush(queue_flush), .exec_valid(exec_valid),
      .exec_addr(exec_addr), .exec_class(exec_class),
      .exec_taken(exec_taken), .exec_dest(exec_dest),
      .event_valid(event_valid), .event_data(event_data),
      .trigger_hit(trigger_hit));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
      reg_addr <= ~a;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
   task automatic rd16(output logic [15:0] v);
      logic [7:0] h, l;
      rd(`DTF_ADDR_HIGH, h);
      rd(`DTF_ADDR_LOW, l);
      v = {h, l};
   endtask
   task automatic pause(input int n);
      repeat (n) cpu.idle();
   endtask
   task automatic count_is(input logic [3:0] n);
      chk({12'h000, fifo_valid_count}, {12'h000, n});
   endtask
   task automatic do_reset();
      @(posedge clock);
      reset <= 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      count_is(4'h0);
      rd(`DTF_ADDR_STATUS, b);
      chk({8'h00, b}, 16'h0000);
      rd(`DTF_ADDR_CTRL, b);
      chk({8'h00, b}, 16'h0000);
      wr(4'h7, 8'hff);
      rd(4'h7, b);
      chk({8'h00, b}, 16'h0000);
   endtask
   task automatic t_profile();
      cpu.fetch(16'h1234, 1'b0);
      rd(`DTF_ADDR_LOW, b);
      pause(3);
      count_is(4'h1);
      cpu.fetch(16'h5678, 1'b0);
      rd16(w);
      chk(w, 16'h1234);
      pause(3);
      count_is(4'h1);
      rd16(w);
      chk(w, 16'h5678);
   endtask
   task automatic t_begin();
      logic [15:0] exp_q[8] = '{16'h0440, 16'h1000, 16'h2000, 16'h3000,
         16'h4000, 16'h5000, 16'h0450, 16'h0460};
      wr(`DTF_ADDR_CTRL, 8'h01);
      pause(2);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0100, 1'b1, 16'h0, 1'b1);
      cpu.op(dtf_pkg::DTF_OP_JUMP_IND, 16'h0110, 1'b0, 16'h0200, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_INTERRUPT, 16'h0120, 1'b0, 16'h0300, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0440, 1'b1, 16'h0, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_SEQ, 16'h0400, 1'b1, 16'h0999, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_BRANCH_ALWAYS, 16'h0410, 1'b1, 16'h0998, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_BRANCH_NEVER, 16'h0420, 1'b1, 16'h0997, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0430, 1'b0, 16'h0996, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_JUMP_IND, 16'h0480, 1'b0, 16'h1000, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_CALL_IND, 16'h0490, 1'b0, 16'h2000, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_INTERRUPT, 16'h04a0, 1'b0, 16'h3000, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_INT_RETURN, 16'h04b0, 1'b0, 16'h4000, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_SUB_RETURN, 16'h04c0, 1'b0, 16'h5000, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0450, 1'b1, 16'h0, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0460, 1'b1, 16'h0, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0470, 1'b1, 16'h0, 1'b0);
      pause(4);
      count_is(4'h8);
      rd(`DTF_ADDR_STATUS, b);
      chk({8'h00, b}, 16'h0068);
      for (int i = 0; i < 7 - int'(fifo_valid_count); i++) begin
         rd(`DTF_ADDR_LOW, b);
      end
      for (int i = 0; i < 8; i++) begin
         rd16(w);
         chk(w, exp_q[i]);
      end
      pause(2);
      count_is(4'h0);
   endtask
   task automatic t_event();
      wr(`DTF_ADDR_CTRL, 8'h03);
      pause(2);
      cpu.trig();
      pause(4);
      cpu.send_event(8'ha5);
      cpu.send_event(8'h3c);
      cpu.send_event(8'h81);
      pause(3);
      count_is(4'h3);
      rd(`DTF_ADDR_HIGH, b);
      chk({8'h00, b}, 16'h0000);
      rd(`DTF_ADDR_LOW, b);
      chk({8'h00, b}, 16'h00a5);
      rd(`DTF_ADDR_LOW, b);
      chk({8'h00, b}, 16'h003c);
      pause(2);
      count_is(4'h1);
   endtask
   task automatic t_end();
      wr(`DTF_ADDR_CTRL, 8'h05);
      pause(2);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0600, 1'b1, 16'h0, 1'b0);
      cpu.op(dtf_pkg::DTF_OP_JUMP_IND, 16'h0610, 1'b0, 16'h7000, 1'b1);
      cpu.op(dtf_pkg::DTF_OP_COND, 16'h0620, 1'b1, 16'h0, 1'b0);
      pause(3);
      count_is(4'h2);
      rd16(w);
      chk(w, 16'h0600);
      rd16(w);
      chk(w, 16'h7000);
   endtask
   task automatic t_tag();
      cpu.fetch(16'h0800, 1'b1);
      cpu.op(dtf_pkg::DTF_OP_SEQ, 16'h0800, 1'b0, 16'h0, 1'b0);
      cpu.idle();
      #1 chk({15'h0, tag_fire}, 16'h0001);
      cpu.fetch(16'h0810, 1'b1);
      cpu.flush();
      cpu.op(dtf_pkg::DTF_OP_SEQ, 16'h0810, 1'b0, 16'h0, 1'b0);
      repeat (3) begin
         cpu.idle();
         #1 chk({15'h0, tag_fire}, 16'h0000);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      {reg_write, reg_read} = 2'h0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_profile();
      do_reset();
      t_begin();
      do_reset();
      t_event();
      do_reset();
      t_end();
      do_reset();
      t_tag();
      end_sim();
   end
   initial begin
      #100us;
      err_count++;
      end_sim();
   end
endmodule
